// >>> logic/pwg_core.sv
// one 10-bit wave generator instance with its byte register port
`timescale 1ns/1ps
`include "pwg_defines.svh"

module pwg_core #(
  parameter int INSTANCE = 0
) (
  input  wire logic            sys_clk_i,
  input  wire logic            rst_b_i,
  input  wire logic            fast_osc_tick_i,
  input  wire logic            cmp_result_i,
  input  wire logic            gate_strap_i,
  input  wire logic [2:0]      addr_i,
  input  wire pwg_pkg::pwg_byte_t wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output pwg_pkg::pwg_byte_t   rdata_o,
  output logic [3:0]           pin_out_o,
  output logic [3:0]           pin_oe_o,
  output logic                 irq_o
);
  import pwg_pkg::*;

  pwg_state_s s_reg;
  pwg_state_s s_next;

  ////////////////////////////////////////////////////////////////////////////////
  // decoded fields
  logic [9:0]  bound;
  logic [9:0]  duty_u;
  logic        duty_half;
  logic [1:0]  ps;
  logic [4:0]  k;
  logic [5:0]  pre_max;
  logic [11:0] pos;
  logic [11:0] div_total;
  logic        first_half;
  logic        src_tick;
  logic        en;
  logic        stop;
  logic        lvl;
  logic        step;
  logic [9:0]  cnt_step;
  logic [2:0]  npins;
  logic        pin_sel;

  assign bound      = {s_reg.bound_h, s_reg.bound_l[`PWG_LOW_TOP]};
  assign duty_u     = {s_reg.duty_h, s_reg.duty_l[`PWG_LOW_TOP]};
  assign duty_half  = s_reg.duty_l[`PWG_LOW_HALF];
  assign ps         = s_reg.scale[`PWG_SCL_PRE];
  assign k          = s_reg.scale[`PWG_SCL_DIV];
  assign en         = s_reg.ctrl[`PWG_CTRL_EN];
  // system clock counts every cycle, the oscillator only on its tick
  assign src_tick   = s_reg.ctrl[`PWG_CTRL_CLK] ? fast_osc_tick_i : 1'b1;
  assign npins      = (INSTANCE == `PWG_WIDE_INST) ? `PWG_PINS_WIDE : `PWG_PINS_NARROW;
  assign stop       = s_reg.gate_opt & s_reg.cmp_q;
  assign lvl        = en & ~stop & (s_reg.wave ^ s_reg.ctrl[`PWG_CTRL_INV]);

  always_comb begin
    unique case (ps)
      2'h0: pre_max = `PWG_PRE_LIM_1;
      2'h1: pre_max = `PWG_PRE_LIM_4;
      2'h2: pre_max = `PWG_PRE_LIM_16;
      2'h3: pre_max = `PWG_PRE_LIM_64;
    endcase
  end

  // position inside one counter tick, in source clocks, for the half step
  assign pos        = (12'(s_reg.sc_cnt) << {ps, 1'b0}) | 12'(s_reg.pre_cnt);
  assign div_total  = (12'(k) + 12'h001) << {ps, 1'b0};
  // with a divisor of one the half step cannot be resolved and is dropped
  assign first_half = pos < (div_total >> 1);

  // counter advances once per prescale times scaler-plus-one source clocks
  assign step       = en & src_tick & (s_reg.pre_cnt >= pre_max)
                    & (s_reg.sc_cnt >= k);
  assign cnt_step   = (s_reg.cnt >= bound) ? 10'h000 : s_reg.cnt + 10'h001;

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_next       = s_reg;
    s_next.irq   = 1'b0;
    s_next.rdata = `PWG_BYTE_RST;
    pin_sel      = 1'b0;

    // comparator and strap are asynchronous; third flop confirms a change
    s_next.sync1 = {gate_strap_i, cmp_result_i};
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    if (s_reg.sync2[0] == s_reg.sync3[0]) begin
      s_next.cmp_q = s_reg.sync3[0];
    end
    if (s_reg.sync2[1] == s_reg.sync3[1]) begin
      s_next.gate_opt = s_reg.sync3[1];
    end

    // dividers and counter
    if (!en) begin
      s_next.pre_cnt = 6'h00;
      s_next.sc_cnt  = 5'h00;
      s_next.cnt     = 10'h000;
    end else if (src_tick) begin
      if (s_reg.pre_cnt >= pre_max) begin
        s_next.pre_cnt = 6'h00;
        if (s_reg.sc_cnt >= k) begin
          s_next.sc_cnt = 5'h00;
          s_next.cnt    = cnt_step;
          if (s_reg.scale[`PWG_SCL_IRQ] && cnt_step == duty_u) begin
            s_next.irq = 1'b1;
          end
        end else begin
          s_next.sc_cnt = s_reg.sc_cnt + 5'h01;
        end
      end else begin
        s_next.pre_cnt = s_reg.pre_cnt + 6'h01;
      end
    end

    // high for duty_u whole ticks, then a half or whole extra tick
    s_next.wave = (s_reg.cnt < duty_u)
                | ((s_reg.cnt == duty_u) & (duty_half | first_half));

    // pin routing; a selected pin is driven whatever its port direction
    for (int i = 0; i < 4; i++) begin
      pin_sel = en & (s_reg.ctrl[`PWG_CTRL_PIN] == 2'(i)) & (3'(i) < npins);
      if (INSTANCE == `PWG_OD_INST && i == `PWG_OD_PIN) begin
        s_next.pin_out[i] = 1'b0;
        s_next.pin_oe[i]  = pin_sel & ~lvl;
      end else begin
        s_next.pin_out[i] = pin_sel & lvl;
        s_next.pin_oe[i]  = pin_sel;
      end
    end

    // register writes take effect at once; no shadow copies
    if (wr_i) begin
      unique case (addr_i)
        `PWG_OFF_CTRL:   s_next.ctrl    = wdata_i;
        `PWG_OFF_SCALE: begin
          s_next.scale   = wdata_i;
          s_next.pre_cnt = 6'h00;
          s_next.sc_cnt  = 5'h00;
        end
        `PWG_OFF_DUTYH:  s_next.duty_h  = wdata_i;
        `PWG_OFF_DUTYL:  s_next.duty_l  = wdata_i;
        `PWG_OFF_BOUNDH: s_next.bound_h = wdata_i;
        `PWG_OFF_BOUNDL: s_next.bound_l = wdata_i;
        default: ;
      endcase
    end

    if (rd_i) begin
      unique case (addr_i)
        `PWG_OFF_CTRL:   s_next.rdata = s_reg.ctrl;
        `PWG_OFF_SCALE:  s_next.rdata = s_reg.scale;
        `PWG_OFF_DUTYH:  s_next.rdata = s_reg.duty_h;
        `PWG_OFF_DUTYL:  s_next.rdata = s_reg.duty_l;
        `PWG_OFF_BOUNDH: s_next.rdata = s_reg.bound_h;
        `PWG_OFF_BOUNDL: s_next.rdata = s_reg.bound_l;
        `PWG_OFF_STAT:   s_next.rdata = {lvl, stop, s_reg.wave, 5'h00};
        default:         s_next.rdata = `PWG_BYTE_RST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o   = s_reg.rdata;
  assign pin_out_o = s_reg.pin_out;
  assign pin_oe_o  = s_reg.pin_oe;
  assign irq_o     = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_wrap_tick;
    step && (s_reg.cnt >= bound);
  endsequence

  sequence s_gated;
    en && s_reg.gate_opt && s_reg.cmp_q;
  endsequence

  property p_wrap;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    s_wrap_tick |=> (s_reg.cnt == 10'h000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap at bound");

  property p_pre;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !wr_i |=> (s_reg.pre_cnt <= pre_max);
  endproperty
  a_pre: assert property (p_pre) else $error("prescaler beyond its limit");

  property p_hold;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (en && !step && !wr_i) |=> $stable(s_reg.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without a step");

  property p_irq;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    irq_o |-> ($past(step) && $past(s_reg.scale[`PWG_SCL_IRQ])
              && (s_reg.cnt == duty_u || $past(wr_i)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pulse without duty match");

  property p_high;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (s_reg.cnt < duty_u) |=> s_reg.wave;
  endproperty
  a_high: assert property (p_high) else $error("wave low inside duty");

  property p_low;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (s_reg.cnt > duty_u) |=> !s_reg.wave;
  endproperty
  a_low: assert property (p_low) else $error("wave high past duty");

  property p_half;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (s_reg.cnt == duty_u && duty_half) |=> s_reg.wave;
  endproperty
  a_half: assert property (p_half) else $error("half step bit ignored");

  property p_gate;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    s_gated ##1 s_gated |=> (pin_out_o == 4'h0);
  endproperty
  a_gate: assert property (p_gate) else $error("output drove high while gated");

  property p_off;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !en |=> (pin_oe_o == 4'h0 && pin_out_o == 4'h0);
  endproperty
  a_off: assert property (p_off) else $error("pin driven while disabled");

  property p_route;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (en && s_reg.ctrl[`PWG_CTRL_PIN] == 2'h0) |=> pin_oe_o[0];
  endproperty
  a_route: assert property (p_route) else $error("selected pin not driven");

  property p_od;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (INSTANCE == `PWG_OD_INST) |-> !pin_out_o[`PWG_OD_PIN];
  endproperty
  a_od: assert property (p_od) else $error("open drain pin driven high");

  property p_rd;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (rd_i && addr_i == `PWG_OFF_CTRL) |=> (rdata_o == $past(s_reg.ctrl));
  endproperty
  a_rd: assert property (p_rd) else $error("control read back wrong");

  // read data must not linger, software may poll back to back
  property p_rd_idle;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !rd_i |=> (rdata_o == `PWG_BYTE_RST);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  // released open drain pin must be pulled low while the level is low
  property p_od_drive;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (INSTANCE == `PWG_OD_INST && en && s_reg.ctrl[`PWG_CTRL_PIN] == 2'(`PWG_OD_PIN) && !lvl)
    |=> pin_oe_o[`PWG_OD_PIN];
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("open drain pin not pulled low");

  property p_no_irq;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !s_reg.scale[`PWG_SCL_IRQ] |=> !irq_o;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt without its option");

  property p_scl_clr;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (wr_i && addr_i == `PWG_OFF_SCALE) |=> (s_reg.pre_cnt == 6'h00 && s_reg.sc_cnt == 5'h00);
  endproperty
  a_scl_clr: assert property (p_scl_clr) else $error("dividers kept after scale write");

  property p_off_clr;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !en |=> (s_reg.cnt == 10'h000);
  endproperty
  a_off_clr: assert property (p_off_clr) else $error("counter kept while disabled");

  // a comparator level held four cycles has passed the synchroniser
  sequence s_cmp_held;
    cmp_result_i [*4];
  endsequence

  property p_cmp_sync;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    s_cmp_held |=> s_reg.cmp_q;
  endproperty
  a_cmp_sync: assert property (p_cmp_sync) else $error("comparator level not taken");

endmodule : pwg_core

// >>> logic/pwg_defines.svh
// register map, field positions and reset values of the wave generator
//
// Behaviour
// - count from system clock or the internal fast oscillator tick, chosen by control
// - scale bits 6:5 divide the chosen clock by 1, 4, 16 or 64
// - scale bits 4:0 further divide by their value plus one
// - period equals prescale times scaler-plus-one times bound-plus-one source clocks
// - 10-bit counter bound is bound high byte then bound low bits 7:6
// - duty upper bits are duty high byte then duty low bits 7:6
// - duty low bit 5 is the half-step duty bit
// - high time is duty upper plus half step plus one half, over bound plus one; with a divisor of one the code adds no half when the half-step bit is clear
// - output high during the duty part of each period, low for the rest
// - pin select routes output to one of three pins, four on the third instance
// - a routed output drives its pin regardless of the port direction
// - second pin of the third instance is open drain only, needs a pull-up
// - all three instances share this design, differing only in pin choices
// - a programming-time strap lets the comparator result gate the output
// - with gating, output stops while comparator is 1, resumes when it is 0
`ifndef PWG_DEFINES_SVH
`define PWG_DEFINES_SVH

`define PWG_OFF_CTRL   3'h0
`define PWG_OFF_SCALE  3'h1
`define PWG_OFF_DUTYH  3'h2
`define PWG_OFF_DUTYL  3'h3
`define PWG_OFF_BOUNDH 3'h4
`define PWG_OFF_BOUNDL 3'h5
`define PWG_OFF_STAT   3'h6

`define PWG_BYTE_RST   8'h00
`define PWG_CTRL_EN    7
`define PWG_CTRL_INV   6
`define PWG_CTRL_CLK   5
`define PWG_CTRL_PIN   1:0
`define PWG_SCL_IRQ    7
`define PWG_SCL_PRE    6:5
`define PWG_SCL_DIV    4:0
`define PWG_LOW_TOP    7:6
`define PWG_LOW_HALF   5
`define PWG_OD_INST    2
`define PWG_OD_PIN     1
`define PWG_WIDE_INST  2
`define PWG_PINS_WIDE  3'h4
`define PWG_PINS_NARROW 3'h3
`define PWG_PRE_LIM_1  6'h00
`define PWG_PRE_LIM_4  6'h03
`define PWG_PRE_LIM_16 6'h0f
`define PWG_PRE_LIM_64 6'h3f

`endif

// >>> logic/pwg_pkg.sv
// types of the wave generator
package pwg_pkg;

  typedef logic [7:0] pwg_byte_t;

  typedef struct packed {
    pwg_byte_t   ctrl;
    pwg_byte_t   scale;
    pwg_byte_t   duty_h;
    pwg_byte_t   duty_l;
    pwg_byte_t   bound_h;
    pwg_byte_t   bound_l;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  sync3;
    logic        cmp_q;
    logic        gate_opt;
    logic [5:0]  pre_cnt;
    logic [4:0]  sc_cnt;
    logic [9:0]  cnt;
    logic        wave;
    logic        irq;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
    pwg_byte_t   rdata;
  } pwg_state_s;

endpackage : pwg_pkg

// >>> bench/pwg_load.sv
// external load on the four generator pins
`timescale 1ns/1ps
module pwg_load (
  input  wire logic       sys_clk_i,
  input  wire logic [3:0] pin_out_i,
  input  wire logic [3:0] pin_oe_i,
  output logic      [3:0] level_o
);
  logic [3:0] last_reg = 4'h0;
  always_ff @(posedge sys_clk_i) last_reg <= level_o;
  // a floating pin other than pin 1 flips each cycle so a stale level never passes for a drive; pin 1 is pulled high
  always_comb begin
    level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ~last_reg);
    if (pin_oe_i[1] !== 1'b1) level_o[1] = 1'b1;
  end
endmodule : pwg_load

// >>> bench/pwg_core_tb.sv
// self-checking bench of the wave generator against the period equations and a register model
`timescale 1ns/1ps
module pwg_core_tb;
  import pwg_pkg::*;
  logic       sys_clk_i, rst_b_i, tick, cmp, strap, wr, rd, irq;
  logic [2:0] addr;
  pwg_byte_t  wdata, rdata;
  logic [3:0] pout, poe, lvl;
  int         n_fail, compares, seed, hi, ir;
  int         mreg [8];
  // pre, scaler, bound, duty, half, invert, pin, fast clock
  int cfg [6][8] = '{'{0,0,3,1,1,0,0,0}, '{1,1,5,2,0,1,1,0}, '{2,2,2,0,1,0,2,0},
                     '{3,0,1,1,0,0,3,0}, '{0,0,4,2,0,0,0,1}, '{0,0,299,150,0,0,3,0}};
  pwg_core #(.INSTANCE(2)) u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .fast_osc_tick_i(tick), .cmp_result_i(cmp), .gate_strap_i(strap), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pin_out_o(pout),
    .pin_oe_o(poe), .irq_o(irq));
  pwg_load u_load (.sys_clk_i(sys_clk_i), .pin_out_i(pout), .pin_oe_i(poe), .level_o(lvl));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) tick <= ~tick;
  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk_byte(string nm, pwg_byte_t e, pwg_byte_t g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic chk_int(string nm, int e, int g);
    compares++;
    if (g != e) begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_int
  task automatic wr_reg(int a, int d);
    @(posedge sys_clk_i);
    addr  <= a[2:0];
    wdata <= d[7:0];
    wr    <= 1'b1;
    if (a < 6) mreg[a] = d & 255;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(int a);
    @(posedge sys_clk_i);
    addr <= a[2:0];
    rd   <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1;
    chk_byte("read data", mreg[a][7:0], rdata);
  endtask : rd_reg
  task automatic meas(int pin, int n);
    hi = 0;
    ir = 0;
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
      hi += (lvl[pin] === 1'b1);
      ir += (irq === 1'b1);
    end
  endtask : meas
  // expected high time from the period equations, counted in system clocks
  task automatic run_cfg(int i);
    int p, u, per, eh, bd, du;
    p  = (1 << (2 * cfg[i][0])) * (cfg[i][1] + 1);
    u  = p * (cfg[i][7] ? 2 : 1);
    bd = cfg[i][2];
    du = cfg[i][3];
    per = u * (bd + 1);
    eh = u * du + (cfg[i][4] ? u : (p > 1 ? u / 2 : 0));
    if (cfg[i][5] != 0) eh = per - eh;
    wr_reg(0, 0);
    wr_reg(1, 128 | (cfg[i][0] << 5) | cfg[i][1]);
    wr_reg(2, du >> 2);
    wr_reg(3, ((du & 3) << 6) | (cfg[i][4] << 5));
    wr_reg(4, bd >> 2);
    wr_reg(5, (bd & 3) << 6);
    wr_reg(0, 128 | (cfg[i][5] << 6) | (cfg[i][7] << 5) | cfg[i][6]);
    repeat (2 * per + 6) @(posedge sys_clk_i);
    meas(cfg[i][6], per);
    chk_int("high time", eh, hi);
    chk_int("irq count", 1, ir);
    chk_byte("other enables", 8'h00, {4'h0, poe & ~(4'h1 << cfg[i][6])});
    $display("test config %0d done", i);
  endtask : run_cfg
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    n_fail++;
    give_verdict();
  end
  initial begin
    seed = 2;
    {n_fail, compares} = '0;
    {rst_b_i, tick, cmp, wr, rd, addr, wdata} = '0;
    strap = 1'b1;
    foreach (mreg[a]) mreg[a] = 0;
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    for (int a = 0; a < 8; a++) rd_reg(a);
    $display("test reset values done");
    // status is live, so only the stored and unmapped places are written
    for (int a = 0; a < 8; a++) begin
      if (a != 6) begin
        wr_reg(a, $random(seed));
        rd_reg(a);
      end
    end
    wr_reg(0, 0);
    repeat (3) @(posedge sys_clk_i);
    chk_byte("enables off", 8'h00, {4'h0, poe});
    $display("test register access done");
    for (int i = 0; i < 6; i++) run_cfg(i);
    // pin 0, period 4, high 2: any 4-cycle window holds exactly 2 high
    run_cfg(0);
    @(posedge sys_clk_i);
    cmp <= 1'b1;
    repeat (16) @(posedge sys_clk_i);
    meas(0, 4);
    chk_int("gated high", 0, hi);
    @(posedge sys_clk_i);
    cmp <= 1'b0;
    repeat (16) @(posedge sys_clk_i);
    meas(0, 4);
    chk_int("resumed high", 2, hi);
    @(posedge sys_clk_i);
    strap <= 1'b0;
    cmp   <= 1'b1;
    repeat (16) @(posedge sys_clk_i);
    meas(0, 4);
    chk_int("ungated high", 2, hi);
    $display("test comparator gate done");
    give_verdict();
  end
endmodule : pwg_core_tb
